// ---- pcg_map.svh ----
// Offsets, field positions, reset values and timing counts of the press cycle guard
//
// Function
// - Overrun check only when overrun cam enabled
// - Pass: feedback rises after cycle end, or high
// - Failing check drops enable, raises overrun fault
// - Suppression holds enable low, stops all checks
// - Suppression never sets or clears faults
// - Error reset accepted while suppressed
// - Suppression fall reinitialises; enable returns high if no fault stands
// - Rearm policy: never, permit/motion, permit/cycle, always
// - Minimum rearm pulse selectable, two values
// - Motion rise starts, motion low stops
// - Motion stop needs rearm under that policy
// - Static permit low drops enable at once
// - Configured start permit gates enable rising
// - Start permit ignored once enable high
// - Guard on: cycle end rise drops enable
// - Cycle end high while top cam low
// - Guard off: motion rise raises enable if allowed
// - Rearm pulse between minimum and upper limit
// - Rearm pending high while awaiting rearm
`ifndef PCG_MAP_SVH
`define PCG_MAP_SVH

// ************************************************************
// Register map
// ************************************************************
`define PCG_ADDR_W       4
`define PCG_CTRL_OFS     4'h0
`define PCG_STAT_OFS     4'h4
`define PCG_CTRL_W       6
`define PCG_CTRL_RST     6'h01
`define PCG_F_OVR_EN     0
`define PCG_F_REARM_LO   1
`define PCG_F_REARM_HI   2
`define PCG_F_LONG       3
`define PCG_F_START_USE  4
`define PCG_F_GUARD      5
`define PCG_RESP_OKAY    2'h0
`define PCG_RESP_SLVERR  2'h2

// ************************************************************
// Timing
// ************************************************************
`define PCG_CLK_KHZ        20000
`define PCG_PULSE_SHORT_MS 100
`define PCG_PULSE_LONG_MS  350
`define PCG_PULSE_MAX_S    30

`endif

// ---- pcg_pkg.sv ----
// Types shared by the press cycle guard modules
package pcg_pkg;
    // Rearm policy of the setup stage
    typedef enum logic [1:0] {
        PCG_RE_NEVER,
        PCG_RE_PERMIT_MOTION,
        PCG_RE_PERMIT_CYCLE,
        PCG_RE_ALWAYS
    } pcg_rearm_type;

    // Overrun watch over one press cycle
    typedef enum logic [1:0] {
        PCG_OV_IDLE,
        PCG_OV_ARMED,
        PCG_OV_SEEN
    } pcg_ovr_type;
endpackage

// ---- pcg_setup_stage.sv ----
// Press setup stage: drive enable and rearm handling
`include "pcg_map.svh"
module pcg_setup_stage #(
    parameter int unsigned SHORT_CYCLES = 32'd2000000, // Short rearm pulse
    parameter int unsigned LONG_CYCLES  = 32'd7000000, // Long rearm pulse
    parameter int unsigned MAX_CYCLES   = 32'd600000000 // Longest pulse
) (
    input  logic                  clock,         // System clock
    input  logic                  reset_n,       // Async reset
    input  logic                  staticPermit,  // Static permit
    input  logic                  startPermit,   // Start permit
    input  logic                  motionRequest, // Motion request
    input  logic                  cycleEnd,      // Cycle-end flag
    input  logic                  rearmRequest,  // Rearm button
    input  pcg_pkg::pcg_rearm_type rearmPolicy,  // Rearm policy
    input  logic                  longPulse,     // Long minimum pulse
    input  logic                  startUsed,     // Start permit configured
    input  logic                  guardOn,       // One-cycle guard
    output logic                  enable,        // Drive enable
    output logic                  rearmPending   // Awaiting rearm
);
    import pcg_pkg::*;

    logic        prevMotion, prevCycle, prevRearm, prevStatic; // Last samples
    logic [31:0] pulseCount;                                   // Rearm high time
    logic        next_enable, next_pending;
    logic [31:0] next_count;
    logic        motionRise, motionFall, cycleRise, staticFall, rearmFall;
    logic        validRearm, stopEvent;
    logic        riseOk;                                       // Start allowed now

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        motionRise = motionRequest & ~prevMotion;
        motionFall = ~motionRequest & prevMotion;
        cycleRise  = cycleEnd & ~prevCycle;
        staticFall = ~staticPermit & prevStatic;
        rearmFall  = ~rearmRequest & prevRearm;
        // Kept apart so the rise check below can look one cycle back
        riseOk     = ~rearmPending & motionRequest & (~startUsed | startPermit);
        // Count saturates just past the limit so overlong pulses stay invalid
        next_count = pulseCount;
        if (!rearmRequest) begin
            next_count = 32'h0;
        end else if (pulseCount <= MAX_CYCLES) begin
            next_count = pulseCount + 32'h1;
        end
        validRearm = rearmFall && pulseCount <= MAX_CYCLES
                     && pulseCount >= (longPulse ? LONG_CYCLES : SHORT_CYCLES);
        // Enable priority: static permit, guard, stop, then start
        next_enable = enable;
        if (!staticPermit) begin
            next_enable = 1'b0;
        end else if (guardOn && cycleRise) begin
            next_enable = 1'b0;
        end else if (!motionRequest) begin
            next_enable = 1'b0;
        end else if (!enable && motionRise && !rearmPending
                     && (!startUsed || startPermit)) begin
            next_enable = 1'b1;
        end
        stopEvent = 1'b0;
        unique case (rearmPolicy)
            PCG_RE_NEVER:         stopEvent = 1'b0;
            PCG_RE_PERMIT_MOTION: stopEvent = staticFall | motionFall;
            PCG_RE_PERMIT_CYCLE:  stopEvent = staticFall | cycleRise;
            PCG_RE_ALWAYS:        stopEvent = enable & ~next_enable;
        endcase
        // A stop in the same cycle as a valid rearm keeps the rearm pending
        next_pending = stopEvent | (rearmPending & ~validRearm);
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            enable       <= 1'b0;
            rearmPending <= 1'b0;
            pulseCount   <= 32'h0;
            prevMotion   <= 1'b0;
            prevCycle    <= 1'b0;
            prevRearm    <= 1'b0;
            prevStatic   <= 1'b0;
        end else begin
            enable       <= next_enable;
            rearmPending <= next_pending;
            pulseCount   <= next_count;
            prevMotion   <= motionRequest;
            prevCycle    <= cycleEnd;
            prevRearm    <= rearmRequest;
            prevStatic   <= staticPermit;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    chk_static_drop: assert property (!staticPermit |=> !enable)
        else $error("enable stayed high without static permit");
    chk_guard_drop: assert property (guardOn && cycleEnd && !prevCycle |=> !enable)
        else $error("enable survived cycle end with guard on");
    chk_rise_gate: assert property ($rose(enable) |-> $past(riseOk))
        else $error("enable rose without permission");
    chk_pending_set: assert property (rearmPolicy == PCG_RE_PERMIT_MOTION
        && prevMotion && !motionRequest |=> rearmPending)
        else $error("motion stop did not request rearm");
    cov_enable_rise: cover property ($rose(enable));
    cov_rearm_done: cover property ($fell(rearmPending));
endmodule // pcg_setup_stage

// ---- pcg_press_guard.sv ----
// Press cycle guard: overrun monitor, suppression, setup stage, register slave
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`include "pcg_map.svh"
module pcg_press_guard #(
    parameter int unsigned SHORT_CYCLES =
        `PCG_PULSE_SHORT_MS * `PCG_CLK_KHZ,          // Short rearm pulse
    parameter int unsigned LONG_CYCLES  =
        `PCG_PULSE_LONG_MS * `PCG_CLK_KHZ,           // Long rearm pulse
    parameter int unsigned MAX_CYCLES   =
        `PCG_PULSE_MAX_S * 1000 * `PCG_CLK_KHZ       // Longest rearm pulse
) (
    input  logic                   clock,           // 20 MHz clock
    input  logic                   reset_n,         // Async reset
    input  logic                   topCenterCam,    // Top cam pin
    input  logic                   overrunCam,      // Overrun cam pin
    input  logic                   driveRunning,    // Drive command feedback
    input  logic                   motionRequest,   // Motion request pin
    input  logic                   startPermit,     // Start permit pin
    input  logic                   rearmRequest,    // Rearm button pin
    input  logic                   monitorSuppress, // Suppression pin
    input  logic                   errorReset,      // Error reset pin
    output logic                   monitorEnable,   // Monitor enable
    output logic                   overrunFault,    // Overrun error
    output logic                   cycleEnd,        // Cycle-end flag
    output logic                   driveEnable,     // Setup stage enable
    output logic                   rearmPending,    // Rearm awaited
    input  logic [`PCG_ADDR_W-1:0] awaddr,          // Write address
    input  logic                   awvalid,         // Write address valid
    output logic                   awready,         // Write address ready
    input  logic [31:0]            wdata,           // Write data
    input  logic [3:0]             wstrb,           // Write strobes
    input  logic                   wvalid,          // Write data valid
    output logic                   wready,          // Write data ready
    output logic [1:0]             bresp,           // Write response
    output logic                   bvalid,          // Response valid
    input  logic                   bready,          // Response ready
    input  logic [`PCG_ADDR_W-1:0] araddr,          // Read address
    input  logic                   arvalid,         // Read address valid
    output logic                   arready,         // Read address ready
    output logic [31:0]            rdata,           // Read data
    output logic [1:0]             rresp,           // Read response
    output logic                   rvalid,          // Read data valid
    input  logic                   rready           // Read data ready
);
    import pcg_pkg::*;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    localparam int NPIN = 8;
    localparam int P_TOP = 0;
    localparam int P_OVR = 1;
    localparam int P_DRV = 2;
    localparam int P_MOT = 3;
    localparam int P_STA = 4;
    localparam int P_REA = 5;
    localparam int P_SUP = 6;
    localparam int P_ERR = 7;

    logic [NPIN-1:0] pinRaw;   // Pins in one vector
    logic [NPIN-1:0] syncA;    // First stage, read only by sample
    logic [NPIN-1:0] sample;   // Sample of this cycle
    logic [NPIN-1:0] prevSamp; // Sample of the previous cycle

    assign pinRaw = {errorReset, monitorSuppress, rearmRequest, startPermit,
                     motionRequest, driveRunning, overrunCam, topCenterCam};

    // Two flops per pin, then one more for edge detection
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            syncA    <= '0;
            sample   <= '0;
            prevSamp <= '0;
        end else begin
            syncA    <= pinRaw;
            sample   <= syncA;
            prevSamp <= sample;
        end
    end

    // ************************************************************
    // Control register and bus slave
    // ************************************************************
    logic [`PCG_CTRL_W-1:0] ctrl;              // Configuration bits
    logic                   awHave, wHave;     // Halves of a write held
    logic [`PCG_ADDR_W-1:0] awAddrHeld;        // Held write address
    logic [31:0]            wDataHeld;         // Held write data
    logic                   wStrbHeld;         // Held low byte strobe
    logic [`PCG_CTRL_W-1:0] next_ctrl;
    logic                   next_awHave, next_wHave, next_wStrb;
    logic [`PCG_ADDR_W-1:0] next_awAddr;
    logic [31:0]            next_wData, next_rdata, statWord;
    logic                   next_awready, next_wready, next_bvalid;
    logic                   next_arready, next_rvalid;
    logic [1:0]             next_bresp, next_rresp;
    logic                   doWrite, arTake;

    assign statWord = {26'h0, sample[P_SUP], rearmPending, driveEnable,
                       cycleEnd, overrunFault, monitorEnable};

    // Address and data may arrive in either order; one write at a time
    always_comb begin
        next_ctrl   = ctrl;
        next_awHave = awHave | (awvalid & awready);
        next_wHave  = wHave | (wvalid & wready);
        next_awAddr = (awvalid & awready) ? awaddr : awAddrHeld;
        next_wData  = (wvalid & wready) ? wdata : wDataHeld;
        next_wStrb  = (wvalid & wready) ? wstrb[0] : wStrbHeld;
        next_bvalid = bvalid & ~bready;
        next_bresp  = bresp;
        doWrite     = awHave & wHave & ~bvalid;
        if (doWrite) begin
            next_awHave = 1'b0;
            next_wHave  = 1'b0;
            next_bvalid = 1'b1;
            if (awAddrHeld == `PCG_CTRL_OFS) begin
                next_bresp = `PCG_RESP_OKAY;
                if (wStrbHeld) begin
                    next_ctrl = wDataHeld[`PCG_CTRL_W-1:0];
                end
            end else if (awAddrHeld == `PCG_STAT_OFS) begin
                next_bresp = `PCG_RESP_OKAY; // Status ignores writes
            end else begin
                next_bresp = `PCG_RESP_SLVERR; // Unmapped
            end
        end
        next_awready = ~next_awHave & ~next_bvalid & ~doWrite;
        next_wready  = ~next_wHave & ~next_bvalid & ~doWrite;
        // Read side answers one cycle after the address is taken
        arTake      = arvalid & arready;
        next_rvalid = rvalid ? ~rready : arTake;
        next_rdata  = rdata;
        next_rresp  = rresp;
        if (arTake) begin
            if (araddr == `PCG_CTRL_OFS) begin
                next_rdata = {26'h0, ctrl};
                next_rresp = `PCG_RESP_OKAY;
            end else if (araddr == `PCG_STAT_OFS) begin
                next_rdata = statWord;
                next_rresp = `PCG_RESP_OKAY;
            end else begin
                next_rdata = 32'h0;
                next_rresp = `PCG_RESP_SLVERR;
            end
        end
        next_arready = ~next_rvalid;
    end

    // Bus registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl       <= `PCG_CTRL_RST;
            awHave     <= 1'b0;
            wHave      <= 1'b0;
            awAddrHeld <= '0;
            wDataHeld  <= 32'h0;
            wStrbHeld  <= 1'b0;
            awready    <= 1'b0;
            wready     <= 1'b0;
            bvalid     <= 1'b0;
            bresp      <= 2'h0;
            arready    <= 1'b0;
            rvalid     <= 1'b0;
            rdata      <= 32'h0;
            rresp      <= 2'h0;
        end else begin
            ctrl       <= next_ctrl;
            awHave     <= next_awHave;
            wHave      <= next_wHave;
            awAddrHeld <= next_awAddr;
            wDataHeld  <= next_wData;
            wStrbHeld  <= next_wStrb;
            awready    <= next_awready;
            wready     <= next_wready;
            bvalid     <= next_bvalid;
            bresp      <= next_bresp;
            arready    <= next_arready;
            rvalid     <= next_rvalid;
            rdata      <= next_rdata;
            rresp      <= next_rresp;
        end
    end

    // ************************************************************
    // Overrun monitor and suppression
    // ************************************************************
    pcg_ovr_type ovState, next_ovState;  // Watch over one cycle
    logic        next_monEnable, next_fault, next_cycleEnd;
    logic        topFall, ovFall, driveRise, suppressed, checking;
    logic        passNow, errRise;

    always_comb begin
        topFall    = prevSamp[P_TOP] & ~sample[P_TOP];
        ovFall     = prevSamp[P_OVR] & ~sample[P_OVR];
        driveRise  = sample[P_DRV] & ~prevSamp[P_DRV];
        errRise    = sample[P_ERR] & ~prevSamp[P_ERR];
        suppressed = sample[P_SUP];
        checking   = ctrl[`PCG_F_OVR_EN] & ~suppressed & ~overrunFault;
        // Feedback must mirror the drive command, so a high level counts
        passNow    = (ovState == PCG_OV_SEEN) | sample[P_DRV];
        next_cycleEnd = ~sample[P_TOP];
        next_ovState  = ovState;
        if (!checking) begin
            next_ovState = PCG_OV_IDLE;
        end else if (ovFall) begin
            next_ovState = PCG_OV_IDLE;
        end else begin
            unique case (ovState)
                PCG_OV_IDLE:  if (topFall) next_ovState = PCG_OV_ARMED;
                PCG_OV_ARMED: if (driveRise) next_ovState = PCG_OV_SEEN;
                PCG_OV_SEEN:  next_ovState = PCG_OV_SEEN;
                default:      next_ovState = PCG_OV_IDLE; // Unused code
            endcase
        end
        // Suppression alone never touches the fault
        next_fault = overrunFault;
        if (checking && ovFall && !passNow) begin
            next_fault = 1'b1;
        end else if (overrunFault && errRise) begin
            next_fault = 1'b0;
        end
        // Enable rises again once suppression drops and no fault stands
        next_monEnable = ~next_fault & ~suppressed;
    end

    // Monitor registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ovState       <= PCG_OV_IDLE;
            overrunFault  <= 1'b0;
            monitorEnable <= 1'b0;
            cycleEnd      <= 1'b0;
        end else begin
            ovState       <= next_ovState;
            overrunFault  <= next_fault;
            monitorEnable <= next_monEnable;
            cycleEnd      <= next_cycleEnd;
        end
    end

    // ************************************************************
    // Setup stage
    // ************************************************************
    // Monitor enable feeds the static permit, as a press line is wired
    pcg_setup_stage #(
        .SHORT_CYCLES (SHORT_CYCLES),
        .LONG_CYCLES  (LONG_CYCLES),
        .MAX_CYCLES   (MAX_CYCLES)
    ) setupStage (
        .clock         (clock),
        .reset_n       (reset_n),
        .staticPermit  (monitorEnable),
        .startPermit   (sample[P_STA]),
        .motionRequest (sample[P_MOT]),
        .cycleEnd      (cycleEnd),
        .rearmRequest  (sample[P_REA]),
        .rearmPolicy   (pcg_rearm_type'(ctrl[`PCG_F_REARM_HI:`PCG_F_REARM_LO])),
        .longPulse     (ctrl[`PCG_F_LONG]),
        .startUsed     (ctrl[`PCG_F_START_USE]),
        .guardOn       (ctrl[`PCG_F_GUARD]),
        .enable        (driveEnable),
        .rearmPending  (rearmPending)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    chk_overrun_trip: assert property (checking && ovFall && !passNow
        |=> overrunFault && !monitorEnable ##1 !driveEnable)
        else $error("failed overrun check did not trip");
    chk_overrun_pass: assert property (checking && ovFall && passNow
        |=> !overrunFault)
        else $error("passing overrun check raised a fault");
    chk_overrun_off: assert property (!ctrl[`PCG_F_OVR_EN] && !overrunFault
        |=> !overrunFault)
        else $error("fault raised with overrun check disabled");
    chk_suppress_low: assert property (suppressed && !overrunFault
        |=> !monitorEnable && !overrunFault)
        else $error("enable high or fault under suppression");
    chk_suppress_keep: assert property ($rose(suppressed) && !errRise
        |=> overrunFault == $past(overrunFault))
        else $error("suppression changed the fault");
    chk_suppress_exit: assert property ($fell(suppressed) && !overrunFault
        |=> monitorEnable && ovState == PCG_OV_IDLE)
        else $error("no clean restart after suppression");
    chk_reset_error: assert property (suppressed && overrunFault && errRise
        |=> !overrunFault)
        else $error("error reset refused under suppression");
    chk_cycle_flag: assert property (!sample[P_TOP] |=> cycleEnd)
        else $error("cycle end low with top cam low");
    chk_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    cov_overrun_fault: cover property ($rose(overrunFault));
    cov_suppress_exit: cover property ($fell(suppressed) ##1 monitorEnable);
    cov_write_read: cover property (bvalid && bready ##[1:4] rvalid);
endmodule // pcg_press_guard

// ---- pcg_cam_model.sv ----
// Cam switch and drive feedback model that stands around the press guard
module pcg_cam_model (
    input  logic clock,  // System clock
    input  logic go,     // Starts one press cycle
    input  logic enable, // Drive command from the setup stage
    output logic topCam, // Top dead-centre cam
    output logic ovrCam, // Overrun cam
    output logic running // Drive feedback
);
    timeunit 1ns;
    timeprecision 1ns;
    // Feedback is the drive command itself, never a pin
    assign running = enable;
    initial begin
        topCam = 1'b1;
        ovrCam = 1'b1;
    end
    // Top falls, overrun falls, overrun rises, top rises
    always @(posedge go) begin
        @(posedge clock) topCam <= 1'b0;
        repeat (6) @(posedge clock);
        ovrCam <= 1'b0;
        repeat (4) @(posedge clock);
        ovrCam <= 1'b1;
        repeat (4) @(posedge clock);
        topCam <= 1'b1;
    end
endmodule // pcg_cam_model

// ---- pcg_press_guard_tb.sv ----
// Self-checking bench of the press cycle guard
module pcg_press_guard_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, reset_n = 0, go = 0, motionRequest = 0, startPermit = 0;
    logic rearmRequest = 0, monitorSuppress = 0, errorReset = 0;
    logic topCenterCam, overrunCam, driveRunning, monitorEnable, overrunFault;
    logic cycleEnd, driveEnable, rearmPending, awready, wready, bvalid, arready, rvalid;
    logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
    logic [31:0] wdata = 0, rdata, v;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [1:0] bresp, rresp, r;
    int fails = 0, checks_done = 0;
    always #25 clock = ~clock; // 20 MHz
    // Short pulse counts keep rearm runs brief
    pcg_press_guard #(.SHORT_CYCLES(10), .LONG_CYCLES(20), .MAX_CYCLES(100))
        pcg_press_guard_i (.*);
    pcg_cam_model pcg_cam_model_i (.clock, .go, .enable(driveEnable),
        .topCam(topCenterCam), .ovrCam(overrunCam), .running(driveRunning));
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    // Bus write: both halves offered at once, each dropped when taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic pls(input int n);
        rearmRequest <= 1'b1;
        cyc(n);
        rearmRequest <= 1'b0;
        cyc(6);
    endtask
    task automatic run_cycle;
        go <= 1'b1;
        cyc(1);
        go <= 1'b0;
        cyc(26);
    endtask
    task automatic t_regs;
        rd(4'h0);
        chk("ctrl reset", 32'h1, v);
        rd(4'h8);
        chk("unmapped resp", 32'h2, 32'(r));
        wr(4'h0, 32'h3);
        chk("write resp", 32'h0, 32'(r));
        rd(4'h0);
        chk("ctrl", 32'h3, v);
        $display("test regs done");
    endtask
    task automatic t_rearm;
        motionRequest <= 1'b1;
        cyc(8);
        chk("start enable", 32'h1, 32'(driveEnable));
        motionRequest <= 1'b0;
        cyc(8);
        chk("stop enable", 32'h0, 32'(driveEnable));
        chk("pending", 32'h1, 32'(rearmPending));
        pls(4);
        chk("short pulse", 32'h1, 32'(rearmPending));
        pls(12);
        chk("valid pulse", 32'h0, 32'(rearmPending));
        $display("test rearm done");
    endtask
    task automatic t_cycle;
        motionRequest <= 1'b1;
        cyc(8);
        go <= 1'b1;
        cyc(1);
        go <= 1'b0;
        cyc(8);
        chk("cycle end", 32'h1, 32'(cycleEnd));
        cyc(20);
        chk("no fault", 32'h0, 32'(overrunFault));
        motionRequest <= 1'b0;
        cyc(8);
        pls(12);
        $display("test cycle done");
    endtask
    task automatic t_fault;
        wr(4'h0, 32'h0);
        run_cycle;
        chk("check off", 32'h0, 32'(overrunFault));
        wr(4'h0, 32'h1);
        run_cycle;
        chk("fault", 32'h1, 32'(overrunFault));
        chk("mon enable", 32'h0, 32'(monitorEnable));
        // A start while the permit is low must not raise the drive
        motionRequest <= 1'b1;
        cyc(8);
        chk("drive enable", 32'h0, 32'(driveEnable));
        monitorSuppress <= 1'b1;
        cyc(8);
        chk("fault kept", 32'h1, 32'(overrunFault));
        errorReset <= 1'b1;
        cyc(8);
        errorReset <= 1'b0;
        chk("fault cleared", 32'h0, 32'(overrunFault));
        chk("suppressed", 32'h0, 32'(monitorEnable));
        monitorSuppress <= 1'b0;
        cyc(8);
        chk("resumed", 32'h1, 32'(monitorEnable));
        $display("test fault done");
    endtask
    // Start permit, guard, long pulse and the always and permit/cycle rearm policies
    task automatic t_config;
        motionRequest <= 1'b0;
        wr(4'h0, 32'h3e);
        motionRequest <= 1'b1;
        cyc(8);
        chk("start refused", 32'h0, 32'(driveEnable));
        motionRequest <= 1'b0;
        startPermit <= 1'b1;
        cyc(8);
        motionRequest <= 1'b1;
        cyc(8);
        chk("start allowed", 32'h1, 32'(driveEnable));
        startPermit <= 1'b0;
        cyc(8);
        chk("start ignored", 32'h1, 32'(driveEnable));
        run_cycle;
        chk("guard drop", 32'h0, 32'(driveEnable));
        chk("pending always", 32'h1, 32'(rearmPending));
        pls(12);
        chk("long minimum", 32'h1, 32'(rearmPending));
        pls(110);
        chk("too long", 32'h1, 32'(rearmPending));
        pls(24);
        chk("long valid", 32'h0, 32'(rearmPending));
        wr(4'h0, 32'h4);
        motionRequest <= 1'b0;
        cyc(4);
        motionRequest <= 1'b1;
        cyc(8);
        chk("guard off start", 32'h1, 32'(driveEnable));
        run_cycle;
        chk("guard off run", 32'h1, 32'(driveEnable));
        chk("cycle rearm", 32'h1, 32'(rearmPending));
        $display("test config done");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        cyc(8);
        reset_n <= 1'b1;
        cyc(2);
        t_regs;
        t_rearm;
        t_cycle;
        t_fault;
        t_config;
        final_report;
    end
    // Watchdog well beyond the five hundred or so cycles the tests take
    initial begin
        cyc(20000);
        fails++;
        final_report;
    end
endmodule // pcg_press_guard_tb
